// [sfpi_core.sv]
// Purpose: Pin-level serial front end of a serial flash device
// Assumes: Pins are oversampled by clk_sys_i, far faster than the serial clock
// Notes:   Command decoding is outside; bytes are handed over here
`timescale 1ns/1ps
module sfpi_core
  import sfpi_pkg::*;
#(
  parameter int unsigned ADDR_W = SFPI_ADDR_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              sck_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  input  wire logic              pause_n_i,
  input  wire logic              wp_n_i,
  input  wire logic [2:0]        protect_level_i,  // Protect level bits 2..0
  input  wire logic              op_busy_i,        // Program, erase or status write running
  input  wire logic [7:0]        tx_byte_i,        // Next byte to shift out
  input  wire logic [ADDR_W-1:0] wr_addr_i,        // Address of a pending program or erase
  output logic                   so_o,
  output logic                   so_oe_o,
  output logic                   rx_valid_o,       // One-cycle pulse per received byte
  output logic [7:0]             rx_byte_o,
  output logic [7:0]             rx_count_o,       // Bytes received in this selection
  output logic                   tx_load_o,        // Pulse: tx_byte_i was taken
  output logic                   active_o,         // Active power state
  output logic                   standby_o,
  output logic                   armed_o,          // Chip select edge seen since reset
  output logic                   wr_blocked_o
);
  initial begin
    if (ADDR_W < 8) $error("sfpi_core: ADDR_W too small");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_PAUSE} sfpi_state_type;

  // Two-flop synchronisers, then a history stage for edge detection
  sfpi_pins_type s1_q, s2_q, s3_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
      s2_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
      s3_q <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1};
    end else begin
      s1_q <= '{sck: sck_i, cs_n: cs_n_i, si: si_i, pause_n: pause_n_i, wp_n: wp_n_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic       armed_q;                                  // Chip select fall seen since reset

  wire sck_rise = s2_q.sck & ~s3_q.sck;
  wire sck_fall = ~s2_q.sck & s3_q.sck;
  wire cs_fall  = ~s2_q.cs_n & s3_q.cs_n;
  wire cs_rise  = s2_q.cs_n & ~s3_q.cs_n;
  wire selected = ~s2_q.cs_n & armed_q;                 // [R3] [R5]

  sfpi_state_type state_q, state_d;
  logic [2:0] bit_q;
  logic [7:0] sh_in_q, sh_out_q, cnt_q, rx_byte_q;
  logic       rx_valid_q, tx_load_q, so_q, so_oe_q;
  logic       active_q, standby_q, blocked_q;
  logic       hold_pend_q;                              // Pause request awaiting clock low
  logic       rel_pend_q;                               // Release awaiting clock low

  // Pause starts when clock is low, else after next clock fall; same for release
  wire pause_go  = (~s2_q.pause_n) & (~s2_q.sck | sck_fall);   // [R7]
  wire resume_go = s2_q.pause_n & (~s2_q.sck | sck_fall);      // [R7]

  // State selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (selected && !cs_fall && s2_q.pause_n) state_d = ST_SHIFT; // [R8]
      ST_SHIFT: if (!selected) state_d = ST_IDLE;
                else if (pause_go) state_d = ST_PAUSE;
      ST_PAUSE: if (!selected) state_d = ST_IDLE;           // Deselect while paused resets logic
                else if (resume_go) state_d = ST_SHIFT;
      default:  state_d = ST_IDLE;
    endcase
  end

  wire shifting = (state_q == ST_SHIFT) & selected & ~pause_go;  // [R8]
  wire do_rise  = shifting & sck_rise;
  wire do_fall  = shifting & sck_fall;
  wire byte_end = do_rise & (bit_q == 3'h7);

  // Arm on first chip select fall after reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) armed_q <= 1'b0;
    else if (cs_fall) armed_q <= 1'b1;                  // [R5]
  end

  // Input shifting and byte/bit counting
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cs_rise || state_q == ST_IDLE) begin
      bit_q   <= SFPI_BIT_RST;                          // [R13]
      cnt_q   <= SFPI_CNT_RST;                          // [R13]
      sh_in_q <= 8'h00;
    end else if (do_rise) begin
      sh_in_q <= {sh_in_q[6:0], s2_q.si};               // [R2]
      bit_q   <= bit_q + 3'h1;
      if (bit_q == 3'h7) cnt_q <= cnt_q + 8'h01;
    end
  end

  // Received byte hand-off
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_valid_q <= 1'b0;
      rx_byte_q  <= 8'h00;
    end else begin
      rx_valid_q <= byte_end;
      if (byte_end) rx_byte_q <= {sh_in_q[6:0], s2_q.si};
    end
  end

  // Output shifting: new byte loaded at selection and after each full byte
  wire load_out = (state_q == ST_IDLE && state_d == ST_SHIFT) | byte_end;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sh_out_q  <= 8'h00;
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= load_out;
      if (load_out) sh_out_q <= tx_byte_i;
      else if (do_fall && bit_q != SFPI_BIT_RST) sh_out_q <= {sh_out_q[6:0], 1'b0};
    end
  end

  // Serial output pin: driven only while selected and not paused
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= (state_d == ST_SHIFT) & selected;     // [R4] [R8]
      if (do_fall) so_q <= (bit_q == SFPI_BIT_RST) ? sh_out_q[7] : sh_out_q[6]; // [R1]
      else if (load_out) so_q <= tx_byte_i[7];
    end
  end

  // Power state: stays active after deselect until the write operation ends
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      active_q  <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      active_q  <= ~s2_q.cs_n | op_busy_i;              // [R3] [R6]
      standby_q <= s2_q.cs_n & ~op_busy_i;              // [R6]
    end
  end

  // Write-protect check of the pending target address
  logic blk_w;
  sfpi_protect #(.ADDR_W(ADDR_W)) u_protect (
    .addr_i          (wr_addr_i),
    .protect_level_i (protect_level_i),
    .wp_n_i          (s2_q.wp_n),
    .blocked_o       (blk_w)
  );

  // State register and pending flags
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q     <= ST_IDLE;
      blocked_q   <= 1'b0;
      hold_pend_q <= 1'b0;
      rel_pend_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      blocked_q   <= blk_w;                             // [R10]
      hold_pend_q <= (state_q == ST_SHIFT) & ~s2_q.pause_n & ~pause_go;
      rel_pend_q  <= (state_q == ST_PAUSE) & s2_q.pause_n & ~resume_go;
    end
  end

  assign so_o         = so_q;
  assign so_oe_o      = so_oe_q;
  assign rx_valid_o   = rx_valid_q;
  assign rx_byte_o    = rx_byte_q;
  assign rx_count_o   = cnt_q;
  assign tx_load_o    = tx_load_q;
  assign active_o     = active_q;
  assign standby_o    = standby_q;
  assign armed_o      = armed_q;
  assign wr_blocked_o = blocked_q;

  wire unused = hold_pend_q ^ rel_pend_q;
endmodule : sfpi_core

// [sfpi_core_assertions.sv]
// Purpose: Concurrent checks on the pins of the serial front end
// Assumes: Pin changes settle through two sync flops and one register
// Notes:   Bound to sfpi_core below
`timescale 1ns/1ps
module sfpi_core_checker
  import sfpi_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       sck_i,
  input wire logic       cs_n_i,
  input wire logic       pause_n_i,
  input wire logic       wp_n_i,
  input wire logic [2:0] protect_level_i,
  input wire logic       op_busy_i,
  input wire logic       so_oe_o,
  input wire logic       rx_valid_o,
  input wire logic       active_o,
  input wire logic       standby_o,
  input wire logic       armed_o,
  input wire logic       wr_blocked_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Deselect and pause seen long enough to pass the synchronisers
  sequence s_desel; cs_n_i [*5]; endsequence
  sequence s_held; (!pause_n_i && !sck_i) [*5]; endsequence
  a_desel_hiz: assert property (s_desel |-> !so_oe_o) else $error("output driven while deselected");
  a_pause_hiz: assert property (s_held |-> !so_oe_o) else $error("output driven while paused");
  a_pause_ignore: assert property (s_held ##1 !pause_n_i |-> !rx_valid_o) else $error("byte taken in pause");
  a_valid_pulse: assert property (rx_valid_o |=> !rx_valid_o [*7]) else $error("byte strobe too long");
  a_unarmed_quiet: assert property (!armed_o |-> !so_oe_o && !rx_valid_o) else $error("traffic before arm");
  a_arm_on_fall: assert property ($fell(cs_n_i) |-> ##[2:5] armed_o) else $error("select edge not armed");
  a_select_active: assert property ((!cs_n_i) [*5] ##0 armed_o |-> active_o) else $error("selected not active");
  a_busy_awake: assert property (op_busy_i ##1 op_busy_i |-> !standby_o) else $error("standby while busy");
  a_idle_standby: assert property ((cs_n_i && !op_busy_i) [*5] |-> standby_o) else $error("idle not standby");
  a_wp_open: assert property (wp_n_i [*5] |-> !wr_blocked_o) else $error("blocked with protect off");
  a_all_blocked: assert property ((!wp_n_i && protect_level_i == SFPI_BP_ALL) [*5] |-> wr_blocked_o)
    else $error("whole array not blocked");
endmodule : sfpi_core_checker

bind sfpi_core sfpi_core_checker chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .pause_n_i(pause_n_i),
  .wp_n_i(wp_n_i), .protect_level_i(protect_level_i), .op_busy_i(op_busy_i), .so_oe_o(so_oe_o),
  .rx_valid_o(rx_valid_o), .active_o(active_o), .standby_o(standby_o), .armed_o(armed_o),
  .wr_blocked_o(wr_blocked_o)
);

// [sfpi_master_model.sv]
// Purpose: Mode 0 serial bus master facing the flash front end
// Assumes: Each serial clock phase lasts five system cycles
// Notes:   Tasks start and end on a system clock edge
`timescale 1ns/1ps
module sfpi_master_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      pause_n_o
);
  // Idle bus: clock low, deselected
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    pause_n_o = 1'b1;
  end
  // Select or deselect; data line flips once released
  task automatic select(input logic sel);
    @(posedge clk_i);
    cs_n_o <= !sel;
    if (!sel) si_o <= !si_o;
    repeat (6) @(posedge clk_i);
  endtask : select
  // Pause with the clock low; select stays low meanwhile
  task automatic hold(input logic on);
    @(posedge clk_i);
    pause_n_o <= !on;
    repeat (6) @(posedge clk_i);
  endtask : hold
  // Shift n bits MSB first: output read before rise, data set after fall
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      si_o <= tx[i];
      repeat (5) @(posedge clk_i);
      rx = {rx[6:0], so_i};
      sck_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
  endtask : bits
endmodule : sfpi_master_model

// [sfpi_pkg.sv]
// Purpose: Shared constants and types for the serial flash pin interface
// Assumes: Serial pins are sampled by the 100 MHz system clock
// Notes:   Rule summary follows
//
// Summary of operation
// R1: Each output bit is shifted onto the serial output on a serial clock fall.
// R2: Command, address and data bits are sampled from serial input on clock rise.
// R3: Chip select low selects the device, active power, traffic accepted.
// R4: Chip select high deselects and keeps the serial output high impedance.
// R5: No command is accepted before a chip select falling edge after power-up.
// R6: Standby only when deselected and no program, erase or status write runs.
// R7: Pause low suspends communication without deselecting; transfer resumes later.
// R8: While paused, output is high impedance and clock and data are ignored.
// R9: Master keeps chip select low during the whole pause.
// R10: Write protect low blocks program or erase inside the protected region.
// R11: Three protect bits select top portion: none, 1/64 up to 1/2, all.
// R12: Master uses mode 0 or mode 3; clock idles low or high.
// R13: Chip select rising edge resets bit and byte counters.
package sfpi_pkg;
  localparam int unsigned SFPI_ADDR_W   = 23;  // Byte address width of the array
  localparam int unsigned SFPI_BYTE_W   = 8;
  localparam int unsigned SFPI_BP_W     = 3;
  localparam logic [2:0]  SFPI_BP_ALL   = 3'h7;
  localparam logic [2:0]  SFPI_BP_NONE  = 3'h0;
  localparam logic [2:0]  SFPI_BIT_RST  = 3'h0;
  localparam logic [7:0]  SFPI_CNT_RST  = 8'h00;

  // Pin group as sampled from the bus master
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic pause_n;
    logic wp_n;
  } sfpi_pins_type;

  // Serial output pin pair
  typedef struct packed {
    logic so;
    logic so_oe;
  } sfpi_out_type;
endpackage : sfpi_pkg

// [sfpi_protect.sv]
// Purpose: Decides whether a byte address lies in the write-protected region
// Assumes: Protected region is the top portion chosen by the protect level
// Notes:   Purely combinational
`timescale 1ns/1ps
module sfpi_protect
  import sfpi_pkg::*;
#(
  parameter int unsigned ADDR_W = SFPI_ADDR_W
) (
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [2:0]        protect_level_i,
  input  wire logic              wp_n_i,
  output logic                   blocked_o
);
  initial begin
    if (ADDR_W < 8) $error("sfpi_protect: ADDR_W too small");
  end

  // Region is the top 2^level of 128 sectors; zero covers none, all-ones covers everything
  wire [6:0] top_sect  = addr_i[ADDR_W-1 -: 7];
  wire [7:0] span      = 8'(8'h01 << protect_level_i);
  wire       in_region = (protect_level_i == SFPI_BP_ALL) ? 1'b1 :
                         (protect_level_i == SFPI_BP_NONE) ? 1'b0 :
                         ({1'b0, top_sect} >= 8'(8'h80 - span)); // [R11]
  assign blocked_o = in_region & ~wp_n_i; // [R10]
endmodule : sfpi_protect

// [tb_serial_flash_pin_interface.sv]
// Purpose: Self-checking bench of the serial flash pin front end
// Assumes: Output byte is a5, changed only inside t_bytes
// Notes:   One task per scenario
`timescale 1ns/1ps
module tb_serial_flash_pin_interface;
  import sfpi_pkg::*;
  logic        clk_sys_i, rst_n_i, wp_n, op_busy;
  logic [2:0]  level;
  logic [22:0] wr_addr;
  logic [7:0]  rx, tx_byte;
  int          failures, checks_done, rx_pulses, tx_loads;
  wire         sck, cs_n, si, pause_n, so, so_oe, active, standby, armed, blocked, rx_valid, tx_load;
  wire  [7:0]  rx_byte, rx_count;
  wire         so_pin = so_oe ? so : 1'bz; // Pin level seen by the master

  sfpi_master_model mdl (.clk_i(clk_sys_i), .so_i(so_pin), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .pause_n_o(pause_n));
  sfpi_core uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .pause_n_i(pause_n), .wp_n_i(wp_n), .protect_level_i(level), .op_busy_i(op_busy), .tx_byte_i(tx_byte),
    .wr_addr_i(wr_addr), .so_o(so), .so_oe_o(so_oe), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
    .rx_count_o(rx_count), .tx_load_o(tx_load), .active_o(active), .standby_o(standby), .armed_o(armed),
    .wr_blocked_o(blocked));

  // Pulse counters for the one-cycle strobes
  always @(posedge clk_sys_i) begin
    if (rx_valid === 1'b1) rx_pulses++;
    if (tx_load === 1'b1) tx_loads++;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic t_bytes();
    mdl.select(1'b1);
    check("active", active, 1'b1);
    tx_byte <= 8'h96;
    mdl.bits(8'h3c, 8, rx);
    check("rx_byte", rx_byte, 8'h3c);
    check("so_data", rx, 8'ha5);
    mdl.bits(8'hc3, 8, rx);
    check("rx_count", rx_count, 8'h02);
    check("so_data2", rx, 8'h96);
    check("rx_pulses", rx_pulses, 2);
    check("tx_loads", tx_loads, 3);
    tx_byte <= 8'ha5;
    mdl.select(1'b0);
    check("so_off", so_oe, 1'b0);
    $display("t_bytes done");
  endtask : t_bytes
  task automatic t_partial();
    mdl.select(1'b1);
    mdl.bits(8'hff, 5, rx);
    mdl.select(1'b0);
    mdl.select(1'b1);
    mdl.bits(8'h81, 8, rx);
    check("rx_byte", rx_byte, 8'h81);
    check("rx_count", rx_count, 8'h01);
    check("so_data", rx, 8'ha5);
    mdl.select(1'b0);
    $display("t_partial done");
  endtask : t_partial
  task automatic t_pause();
    mdl.select(1'b1);
    mdl.bits(8'h5a, 4, rx);
    mdl.hold(1'b1);
    check("so_paused", so_oe, 1'b0);
    mdl.bits(8'hff, 3, rx);
    mdl.hold(1'b0);
    mdl.bits(8'ha0, 4, rx);
    check("rx_byte", rx_byte, 8'h5a);
    check("rx_count", rx_count, 8'h01);
    mdl.select(1'b0);
    $display("t_pause done");
  endtask : t_pause
  task automatic probe(input logic [2:0] l, input logic w, input logic [22:0] a, input logic e);
    level <= l;
    wp_n <= w;
    wr_addr <= a;
    repeat (5) @(posedge clk_sys_i);
    check("wr_blocked", blocked, e);
  endtask : probe
  task automatic t_protect();
    int sz;
    for (int l = 0; l < 8; l++) begin
      sz = (l == 7) ? 32'h800000 : (l == 0) ? 0 : (1 << (16 + l));
      probe(l[2:0], 1'b0, 23'(32'h800000 - sz), sz != 0);
      probe(l[2:0], 1'b0, 23'(32'h7fffff - sz), l == 7);
    end
    probe(3'h7, 1'b1, 23'h0, 1'b0);
    $display("t_protect done");
  endtask : t_protect
  task automatic t_standby();
    op_busy <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check("standby_busy", standby, 1'b0);
    op_busy <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    check("standby_idle", standby, 1'b1);
    $display("t_standby done");
  endtask : t_standby

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    wp_n = 1'b1;
    op_busy = 1'b0;
    level = 3'h0;
    wr_addr = 23'h0;
    tx_byte = 8'ha5;
    rx_pulses = 0;
    tx_loads = 0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check("armed", armed, 1'b0);
    check("standby", standby, 1'b1);
    t_bytes();
    t_partial();
    t_pause();
    t_protect();
    t_standby();
    stop_test();
  end
endmodule : tb_serial_flash_pin_interface
